// >>> startup_pkg.sv
package startup_pkg;
   // Register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int LEN_W = 24;
   localparam int DLY_W = 3;

   // Register offsets
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_LENGTH = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;

   // Control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_DONE_DLY_LSB = 2;
   localparam int CTRL_GSR_DLY_LSB = 5;
   localparam int CTRL_IO_DLY_LSB = 8;
   localparam int CTRL_PULLUP_BIT = 11;
   localparam int CTRL_W = 12;

   // Status field positions
   localparam int STAT_STARTUP_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_GSR_BIT = 2;
   localparam int STAT_IO_BIT = 3;
   localparam int STAT_LINE_BIT = 4;
   localparam int STAT_FRAME_BIT = 5;
   localparam int STAT_RUN_BIT = 6;

   // Extra edges beyond the reference edge, at most four
   localparam logic [DLY_W-1:0] MAX_DELAY = 3'h4;
   localparam logic [DLY_W-1:0] FIRST_EDGE_OFFSET = 3'h1;

   // Reset values
   localparam logic [1:0] MODE_RESET = 2'h1;
   localparam logic [DLY_W-1:0] DELAY_RESET = 3'h0;
   localparam logic PULLUP_RESET = 1'b1;
   localparam logic [LEN_W-1:0] LENGTH_RESET = 24'h000000;

   typedef enum logic [1:0] {
      config_clock_unsynced_mode,
      config_clock_synced_mode,
      user_clock_unsynced_mode,
      user_clock_synced_mode
   } startup_mode_t;

   typedef enum logic [1:0] {
      ST_WAIT_INIT,
      ST_LOAD,
      ST_STARTUP,
      ST_RUN
   } seq_state_t;
endpackage

// >>> completion_sync.sv
`timescale 1ns/100ps
`default_nettype none
module completion_sync
   import startup_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic async_level,
   output logic sync_level
);
   logic stage1_ff;
   logic stage2_ff;

   // Line is driven by other devices, so it is treated as foreign
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_ff <= 1'b0;
         stage2_ff <= 1'b0;
      end else begin
         stage1_ff <= async_level;
         stage2_ff <= stage1_ff;
      end
   end

   assign sync_level = stage2_ff;
endmodule
`default_nettype wire

// >>> startup_event_timer.sv
`timescale 1ns/100ps
`default_nettype none
module startup_event_timer
   import startup_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic arm,
   input wire logic tick,
   input wire logic [DLY_W-1:0] delay,
   output logic fired
);
   logic [DLY_W-1:0] count_ff;
   logic fired_ff;

   // Counts start-up edges while armed; fires once the count meets delay
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_ff <= '0;
         fired_ff <= 1'b0;
      end else if (clear) begin
         count_ff <= '0;
         fired_ff <= 1'b0;
      end else if (arm && !fired_ff) begin
         if (count_ff == delay) begin
            fired_ff <= 1'b1;
         end else if (tick) begin
            count_ff <= count_ff + 3'h1;
         end
      end
   end

   assign fired = fired_ff;
endmodule
`default_nettype wire

// >>> config_startup_sequencer.sv
// Overview of operation
// - Start-up begins when edge count since init equals length and end frame written.
// - Completion release, set/reset release and I/O enable are timed independently.
// - Four modes: config or user clock, each synced or unsynced.
// - User-clock modes time every start-up event from the supplied user clock.
// - Synced: set/reset and I/O events follow programmed edges after line high.
// - Unsynced: set/reset and I/O events counted in edges, ignoring the line.
// - Completion pin only pulled low or released; pull-up enabled by default.
// - Shared wired-AND line reads high only after every device released it.
// - Default mode is config clock synced; completion released on first start-up edge.
// - Synced: line held low externally stalls set/reset and I/O events.
// - Each of the two later events: immediate or one to four more edges.
// - By default both later events occur immediately once the line is high.
// - Mode and delay settings are static; locked once loading has begun.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module config_startup_sequencer
   import startup_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic config_clock,
   input wire logic user_startup_clock,
   input wire logic init_high,
   input wire logic end_frame_written,
   input wire logic config_restart,
   input wire logic done_in,
   output logic done_out,
   output logic done_oe,
   output logic done_pullup_en,
   output logic gsr_hold,
   output logic io_enable,
   output logic startup_active
);
   seq_state_t state_ff;
   seq_state_t nxt_state;
   logic [1:0] mode_ff;
   logic [DLY_W-1:0] done_dly_ff;
   logic [DLY_W-1:0] gsr_dly_ff;
   logic [DLY_W-1:0] io_dly_ff;
   logic pullup_ff;
   logic [LEN_W-1:0] length_ff;
   logic [LEN_W-1:0] edge_cnt_ff;
   logic frame_ff;
   logic config_clock_prev_ff;
   logic user_startup_clock_prev_ff;
   logic done_oe_ff;
   logic done_out_ff;
   logic gsr_hold_ff;
   logic io_enable_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic config_clock_edge;
   logic user_startup_clock_edge;
   logic su_edge;
   logic synced;
   logic use_user;
   logic line_high;
   logic in_startup;
   logic later_arm;
   logic done_fire;
   logic gsr_fire;
   logic io_fire;
   logic len_match;
   logic cfg_locked;
   logic [DLY_W-1:0] done_target;
   logic [DATA_W-1:0] status_word;
   startup_mode_t mode;

   function automatic logic [DLY_W-1:0] clamp_delay(input logic [DLY_W-1:0] d);
      clamp_delay = (d > MAX_DELAY) ? MAX_DELAY : d;
   endfunction

   assign mode = startup_mode_t'(mode_ff);
   assign use_user = (mode == user_clock_unsynced_mode) ||
                     (mode == user_clock_synced_mode);
   assign synced = (mode == config_clock_synced_mode) ||
                   (mode == user_clock_synced_mode);
   assign config_clock_edge = config_clock && !config_clock_prev_ff;
   assign user_startup_clock_edge = user_startup_clock && !user_startup_clock_prev_ff;
   assign su_edge = use_user ? user_startup_clock_edge : config_clock_edge;
   assign in_startup = (state_ff == ST_STARTUP) || (state_ff == ST_RUN);
   assign len_match = (edge_cnt_ff == length_ff);
   assign cfg_locked = (state_ff != ST_WAIT_INIT);
   // First start-up edge is the reference, so the target is one past the setting
   assign done_target = done_dly_ff + FIRST_EDGE_OFFSET;
   // Own drive keeps the wired line low until this device also lets go
   assign later_arm = synced ? (in_startup && line_high) : in_startup;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         config_clock_prev_ff <= 1'b0;
         user_startup_clock_prev_ff <= 1'b0;
      end else begin
         config_clock_prev_ff <= config_clock;
         user_startup_clock_prev_ff <= user_startup_clock;
      end
   end

   completion_sync u_line_sync (
      .clk(clk),
      .reset_n(reset_n),
      .async_level(done_in),
      .sync_level(line_high)
   );

   // Settings accepted only while idle; a running start-up never sees them move
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_ff <= MODE_RESET;
         done_dly_ff <= DELAY_RESET;
         gsr_dly_ff <= DELAY_RESET;
         io_dly_ff <= DELAY_RESET;
         pullup_ff <= PULLUP_RESET;
      end else if (reg_write && (reg_addr == ADDR_CTRL) && !cfg_locked) begin
         mode_ff <= reg_wdata[CTRL_MODE_LSB +: 2];
         done_dly_ff <= clamp_delay(reg_wdata[CTRL_DONE_DLY_LSB +: DLY_W]);
         gsr_dly_ff <= clamp_delay(reg_wdata[CTRL_GSR_DLY_LSB +: DLY_W]);
         io_dly_ff <= clamp_delay(reg_wdata[CTRL_IO_DLY_LSB +: DLY_W]);
         pullup_ff <= reg_wdata[CTRL_PULLUP_BIT];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         length_ff <= LENGTH_RESET;
      end else if (reg_write && (reg_addr == ADDR_LENGTH) && !cfg_locked) begin
         length_ff <= reg_wdata[LEN_W-1:0];
      end
   end

   // Frame mark: a new end frame in the restart cycle still counts
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_ff <= 1'b0;
      end else if (end_frame_written && (state_ff != ST_WAIT_INIT || init_high)) begin
         frame_ff <= 1'b1;
      end else if (config_restart) begin
         frame_ff <= 1'b0;
      end
   end

   // Config clock edges after init rises; holds at the match
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         edge_cnt_ff <= '0;
      end else if (config_restart || state_ff == ST_WAIT_INIT) begin
         edge_cnt_ff <= '0;
      end else if (state_ff == ST_LOAD && config_clock_edge && !len_match) begin
         edge_cnt_ff <= edge_cnt_ff + 24'h000001;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_WAIT_INIT: begin
            if (init_high) begin
               nxt_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (len_match && frame_ff) begin
               nxt_state = ST_STARTUP;
            end
         end
         ST_STARTUP: begin
            if (done_fire && gsr_fire && io_fire) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            nxt_state = ST_RUN;
         end
         default: begin
            nxt_state = ST_WAIT_INIT;
         end
      endcase
      if (config_restart) begin
         nxt_state = ST_WAIT_INIT;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_WAIT_INIT;
      end else begin
         state_ff <= nxt_state;
      end
   end

   startup_event_timer u_done_timer (
      .clk(clk),
      .reset_n(reset_n),
      .clear(config_restart),
      .arm(in_startup),
      .tick(su_edge),
      .delay(done_target),
      .fired(done_fire)
   );

   startup_event_timer u_gsr_timer (
      .clk(clk),
      .reset_n(reset_n),
      .clear(config_restart),
      .arm(later_arm),
      .tick(su_edge),
      .delay(gsr_dly_ff),
      .fired(gsr_fire)
   );

   startup_event_timer u_io_timer (
      .clk(clk),
      .reset_n(reset_n),
      .clear(config_restart),
      .arm(later_arm),
      .tick(su_edge),
      .delay(io_dly_ff),
      .fired(io_fire)
   );

   // Pin only ever pulled low or let go; the level is never driven high
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done_oe_ff <= 1'b1;
         done_out_ff <= 1'b0;
      end else if (config_restart) begin
         done_oe_ff <= 1'b1;
         done_out_ff <= 1'b0;
      end else begin
         done_oe_ff <= !done_fire;
         done_out_ff <= 1'b0;
      end
   end

   // Restart drops the outputs at once, not a cycle after the timers clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gsr_hold_ff <= 1'b1;
         io_enable_ff <= 1'b0;
      end else if (config_restart) begin
         gsr_hold_ff <= 1'b1;
         io_enable_ff <= 1'b0;
      end else begin
         gsr_hold_ff <= !gsr_fire;
         io_enable_ff <= io_fire;
      end
   end

   always_comb begin
      status_word = '0;
      status_word[STAT_STARTUP_BIT] = (state_ff == ST_STARTUP);
      status_word[STAT_DONE_BIT] = done_fire;
      status_word[STAT_GSR_BIT] = gsr_fire;
      status_word[STAT_IO_BIT] = io_fire;
      status_word[STAT_LINE_BIT] = line_high;
      status_word[STAT_FRAME_BIT] = frame_ff;
      status_word[STAT_RUN_BIT] = (state_ff == ST_RUN);
   end

   // Read data live for one cycle only, zero otherwise and for unmapped offsets
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_ff <= '0;
      end else if (reg_read) begin
         case (reg_addr)
            ADDR_CTRL: begin
               rdata_ff <= {20'h00000, pullup_ff, io_dly_ff, gsr_dly_ff, done_dly_ff, mode_ff};
            end
            ADDR_LENGTH: begin
               rdata_ff <= {8'h00, length_ff};
            end
            ADDR_STATUS: begin
               rdata_ff <= status_word;
            end
            default: begin
               rdata_ff <= '0;
            end
         endcase
      end else begin
         rdata_ff <= '0;
      end
   end

   assign reg_rdata = rdata_ff;
   assign done_out = done_out_ff;
   assign done_oe = done_oe_ff;
   assign done_pullup_en = pullup_ff;
   assign gsr_hold = gsr_hold_ff;
   assign io_enable = io_enable_ff;
   assign startup_active = in_startup;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_start_needs_match: assert property (
      (state_ff == ST_LOAD && nxt_state == ST_STARTUP) |-> (len_match && frame_ff))
      else $error("start-up entered without length match and end frame");

   a_pin_open_drain: assert property (done_out == 1'b0)
      else $error("completion pin driven high");

   a_sync_stall: assert property (
      (synced && in_startup && !line_high && !gsr_fire) |=> !gsr_fire)
      else $error("set/reset released while line held low");

   a_sync_io_stall: assert property (
      (synced && in_startup && !line_high && !io_fire) |=> !io_fire)
      else $error("I/O enabled while line held low");

   a_immediate_gsr: assert property (
      (later_arm && gsr_dly_ff == 3'h0 && !gsr_fire && !config_restart) |=>
      gsr_fire ##1 !gsr_hold)
      else $error("zero delay set/reset release not immediate");

   a_delay_bounded: assert property (
      (later_arm && !gsr_fire && !config_restart && u_gsr_timer.count_ff == gsr_dly_ff) |=>
      gsr_fire)
      else $error("set/reset release late after programmed edges");

   a_unsync_ignores_line: assert property (
      (!synced && in_startup && io_dly_ff == 3'h0 && !io_fire && !config_restart) |=>
      io_fire)
      else $error("unsynced I/O event waited on line");

   a_events_sticky: assert property (
      (io_enable && !config_restart) |=> io_enable)
      else $error("I/O enable dropped without restart");

   a_done_sticky: assert property (
      (!done_oe && !config_restart) |=> !done_oe)
      else $error("completion pin pulled low again without restart");

   a_cfg_static: assert property (
      cfg_locked |=> $stable(mode_ff) && $stable(gsr_dly_ff) && $stable(io_dly_ff))
      else $error("start-up settings changed while locked");

   a_user_clock_used: assert property (
      (use_user && in_startup && !user_startup_clock_edge && !done_fire && !config_restart &&
       u_done_timer.count_ff != done_target) |=> $stable(u_done_timer.count_ff))
      else $error("start-up edge counted without user clock");

   a_done_first_edge: assert property (
      (state_ff == ST_LOAD && nxt_state == ST_STARTUP && done_dly_ff == 3'h0) |->
      !done_fire)
      else $error("completion released before first start-up edge");

   c_full_startup: cover property (state_ff == ST_STARTUP ##[1:100] state_ff == ST_RUN);
   c_sync_stall: cover property (synced && in_startup && done_fire && !line_high);
   c_user_mode_run: cover property (use_user && state_ff == ST_RUN);
   c_restart_after_run: cover property (state_ff == ST_RUN ##1 config_restart);
endmodule
`default_nettype wire

// >>> done_line_model.sv
`timescale 1ns/100ps
`default_nettype none
module done_line_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic dut_pulls_low,
   input wire logic peer_holds_low,
   input wire logic cfg_run,
   input wire logic usr_run,
   output logic line_level,
   output logic prom_enabled,
   output logic cfg_clk,
   output logic usr_clk
);
   logic [3:0] div_ff;

   // Pull-up wins only once every party has let go of the line
   assign line_level = !(dut_pulls_low || peer_holds_low);
   // Active-low PROM enable keyed off the shared line
   assign prom_enabled = !line_level;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_ff <= 4'h0;
      end else begin
         div_ff <= div_ff + 4'h1;
      end
   end

   // Clocks stand still unless commanded, so a stray edge cannot mask a stall
   assign cfg_clk = cfg_run && div_ff[2];
   assign usr_clk = usr_run && div_ff[1];
endmodule
`default_nettype wire

// >>> config_startup_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module config_startup_sequencer_bench;
   import startup_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic [DATA_W-1:0] reg_wdata = 32'h00000000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic init_high = 1'b0;
   logic end_frame_written = 1'b0;
   logic config_restart = 1'b0;
   logic peer_low = 1'b1;
   logic cfg_run = 1'b0;
   logic usr_run = 1'b0;
   logic config_clock;
   logic user_startup_clock;
   logic done_line;
   logic prom_en;
   logic done_out;
   logic done_oe;
   logic done_pullup_en;
   logic gsr_hold;
   logic io_enable;
   logic startup_active;
   logic [3:0] obs;
   logic [DATA_W-1:0] rv;
   startup_mode_t md;
   logic prev;
   int edges;
   int fails = 0;
   int num_checks = 0;

   always #2.5 clk = ~clk;
   assign obs = {startup_active, io_enable, gsr_hold, done_oe};

   config_startup_sequencer i_dut (
      .clk(clk),
      .reset_n(reset_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata),
      .config_clock(config_clock),
      .user_startup_clock(user_startup_clock),
      .init_high(init_high),
      .end_frame_written(end_frame_written),
      .config_restart(config_restart),
      .done_in(done_line),
      .done_out(done_out),
      .done_oe(done_oe),
      .done_pullup_en(done_pullup_en),
      .gsr_hold(gsr_hold),
      .io_enable(io_enable),
      .startup_active(startup_active)
   );

   done_line_model i_line (
      .clk(clk),
      .reset_n(reset_n),
      .dut_pulls_low(done_oe),
      .peer_holds_low(peer_low),
      .cfg_run(cfg_run),
      .usr_run(usr_run),
      .line_level(done_line),
      .prom_enabled(prom_en),
      .cfg_clk(config_clock),
      .usr_clk(user_startup_clock)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge clk);
   endtask

   task automatic wait_bit(input int i, input logic v, input int lim);
      int n;
      n = 0;
      while (obs[i] !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, obs[i]}, {31'h0, v});
   endtask

   // Init is dropped in the same cycle as the restart so the settings unlock again
   task automatic restart();
      init_high <= 1'b0;
      end_frame_written <= 1'b0;
      config_restart <= 1'b1;
      @(posedge clk);
      config_restart <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_of_test();
   end

   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(ADDR_CTRL, rv);
      check(rv, 32'h00000801);
      rd(ADDR_LENGTH, rv);
      check(rv, 32'h00000000);
      rd(8'h0C, rv);
      check(rv, 32'h00000000);
      check({28'h0, obs}, 32'h00000003);
      check({31'h0, done_pullup_en}, 32'h00000001);
      check({31'h0, done_out}, 32'h00000000);
      $display("test reset done");

      wr(ADDR_LENGTH, 32'h00000003);
      init_high <= 1'b1;
      cfg_run <= 1'b1;
      repeat (60) @(posedge clk);
      check({31'h0, startup_active}, 32'h00000000);
      wr(ADDR_CTRL, 32'h00000000);
      rd(ADDR_CTRL, rv);
      check(rv, 32'h00000801);
      end_frame_written <= 1'b1;
      wait_bit(3, 1'b1, 40);
      wait_bit(0, 1'b0, 20);
      repeat (40) @(posedge clk);
      check({28'h0, obs}, 32'h0000000A);
      peer_low <= 1'b0;
      wait_bit(1, 1'b0, 12);
      check({28'h0, obs}, 32'h0000000C);
      rd(ADDR_STATUS, rv);
      check(rv, 32'h0000007E);
      repeat (30) @(posedge clk);
      check({28'h0, obs}, 32'h0000000C);
      restart();
      check({28'h0, obs}, 32'h00000003);
      $display("test default synced done");

      // Set/reset immediate, I/O four edges later
      wr(ADDR_CTRL, 32'h00000C01);
      wr(ADDR_LENGTH, 32'h00000000);
      end_frame_written <= 1'b1;
      init_high <= 1'b1;
      wait_bit(1, 1'b0, 80);
      edges = 0;
      prev = config_clock;
      while (io_enable !== 1'b1 && edges < 10) begin
         @(posedge clk);
         if (config_clock && !prev) begin
            edges++;
         end
         prev = config_clock;
      end
      check(edges, 32'h00000004);
      check({31'h0, prom_en}, 32'h00000000);
      $display("test delays done");

      for (int m = 0; m < 3; m++) begin
         restart();
         md = (m == 0) ? config_clock_unsynced_mode :
            ((m == 1) ? user_clock_unsynced_mode : user_clock_synced_mode);
         peer_low <= (m != 2);
         cfg_run <= (m == 0);
         usr_run <= (m != 0);
         wr(ADDR_CTRL, {30'h0, md} | 32'h00000800);
         end_frame_written <= 1'b1;
         init_high <= 1'b1;
         wait_bit(2, 1'b1, 150);
         check({31'h0, done_line}, {31'h0, m == 2});
      end
      $display("test modes done");
      end_of_test();
   end
endmodule
`default_nettype wire
